// ---- rtl/wdg_pkg.sv ----
package wdg_pkg;

  // Register addresses on the plain register port.
  localparam logic [5:0] WDOG_CTRL_ADDR = 6'h31;
  localparam logic [5:0] RST_CAUSE_ADDR = 6'h3b;
  localparam logic [5:0] SUPPLY_MON_ADDR = 6'h3a;
  localparam logic [5:0] CHANGE_PROTECT_ADDR = 6'h3c;
  localparam logic [7:0] CHANGE_SIGNATURE = 8'hd8;

  // Field positions in watchdog_control_status.
  localparam int WDOG_IRQ_FLAG_BIT = 7;
  localparam int WDOG_IRQ_ENABLE_BIT = 6;
  localparam int WDP_HI_BIT = 5;
  localparam int WDE_BIT = 3;

  // Field positions in reset_cause_flags.
  localparam int WDOG_RESET_FLAG_BIT = 3;
  localparam int EXT_PIN_RESET_FLAG_BIT = 1;
  localparam int POWER_ON_RESET_FLAG_BIT = 0;

  // Field positions in supply_monitor_control_status.
  localparam int SUPPLY_MONITOR_FLAG_BIT = 7;
  localparam int SUPPLY_MONITOR_IRQ_ENABLE_BIT = 6;

  // Supply monitor trigger level codes.
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam logic [2:0] LEVEL_POR_LO = 3'h1;
  localparam logic [2:0] LEVEL_POR_HI = 3'h2;
  localparam logic [2:0] LEVEL_FLAG_LO = 3'h3;
  localparam logic [2:0] LEVEL_FLAG_HI = 3'h4;

  // Time-out period: base count of oscillator cycles and highest valid code.
  localparam int CNT_W = 21;
  localparam logic [CNT_W-1:0] PERIOD_BASE = 21'h000800;
  localparam logic [3:0] PERIOD_MAX_CODE = 4'h9;
  localparam logic [3:0] PERIOD_RESET = 4'h0;

  // Clock rates; one instruction cycle is one system clock cycle.
  localparam int REF_CLK_HZ = 100000000;
  localparam int WDOG_OSC_HZ = 128000;
  localparam int CLOCKS_PER_INSTR = 1;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } wdg_bus_req_t;

  typedef struct packed {
    logic [1:0] oscSync;
    logic oscPrev;
    logic [1:0] extSync;
    logic [1:0] supSync;
    logic [1:0] fuseSync;
    logic wdog_irq_flag;
    logic wdog_irq_enable;
    logic wdog_reset_enable;
    logic [3:0] wdog_period_select;
    logic [CNT_W-1:0] cnt;
    logic [2:0] protectCnt;
    logic rstPulse;
    logic [2:0] level;
    logic supply_monitor_irq_enable;
    logic supply_monitor_flag;
    logic trigPrev;
    logic vlmIrq;
    logic [7:0] rdata;
  } wdg_state_t;

  typedef struct packed {
    logic wdog_reset_flag;
    logic ext_pin_reset_flag;
    logic power_on_reset_flag;
  } wdg_flags_t;

endpackage

// ---- rtl/wdg_watchdog.sv ----
// Functional notes
// - Level one: starts off, plain enable write.
// - Level one disable needs signature, then write.
// - Level two: enable always reads one.
// - Level two period change needs signature first.
// - Time-out in interrupt mode sets flag.
// - Flag cleared by vector or writing one.
// - Interrupt request needs flag, enable, global bit.
// - Enable and interrupt-enable bits select mode.
// - Fuse programmed forces reset on time-out.
// - Vector in combined mode clears interrupt-enable, flag.
// - Unserviced combined interrupt resets next time-out.
// - Reset flag forces enable; blocks its clearing.
// - Period code n gives 2048 shl n.
// - Supply flag set on trigger, cleared otherwise.
// - Supply interrupt each time flag sets.
// - Trigger level codes: off, reset, flag.
// - Watchdog reset flag set, cleared by POR/write.
// - Pin reset flag set, cleared by POR/write.
// - Power-on flag cleared only by write.
// - Counter runs from 128 kHz oscillator.
// - Counter restarts on kick, disable, reset.
// - Time-out reset pulse is one cycle.
`timescale 1ns/1ps
`default_nettype none

module wdg_watchdog #(
  parameter int CCP_WINDOW_INSTR = 4
) (
  // Clock and resets
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic porRstn,
  // Register port
  input wire wdg_pkg::wdg_bus_req_t busReq,
  output logic [7:0] busRdata,
  // CPU side
  input wire logic kickReq,
  input wire logic wdogVectorAck,
  input wire logic globalIrqEnable,
  output logic wdogIrqReq,
  output logic supplyMonitorIrq,
  // Pins and analog
  input wire logic wdogOscIn,
  input wire logic extResetPinN,
  input wire logic supplyBelowLevel,
  input wire logic wdogAlwaysOnFuse,
  // Reset requests
  output logic sysResetPulse,
  output logic supplyPorReq
);

  localparam int CCP_WINDOW_CYCLES = CCP_WINDOW_INSTR * wdg_pkg::CLOCKS_PER_INSTR;

  initial
  begin
    if (CCP_WINDOW_CYCLES < 1 || CCP_WINDOW_CYCLES > 7)
      $error("CCP_WINDOW_INSTR must give 1 to 7 cycles");
    if (wdg_pkg::WDOG_OSC_HZ * 4 > wdg_pkg::REF_CLK_HZ)
      $error("Oscillator too fast to sample");
  end

  // Reserved codes above nine run as the longest period rather than stopping.
  function automatic logic [wdg_pkg::CNT_W-1:0] periodLimit(input logic [3:0] code);
    logic [3:0] c;
    c = (code > wdg_pkg::PERIOD_MAX_CODE) ? wdg_pkg::PERIOD_MAX_CODE : code;
    periodLimit = (wdg_pkg::PERIOD_BASE << c) - wdg_pkg::PERIOD_BASE / wdg_pkg::PERIOD_BASE;
  endfunction

  function automatic logic inRange(input logic [2:0] v, input logic [2:0] lo,
                                   input logic [2:0] hi);
    inRange = (v >= lo) && (v <= hi);
  endfunction

  wdg_pkg::wdg_state_t state_ff;
  wdg_pkg::wdg_state_t nxt_state;
  wdg_pkg::wdg_flags_t flags_ff;
  wdg_pkg::wdg_flags_t nxt_flags;

  logic oscTick;
  logic levelTwo;
  logic wdeEff;
  logic protectOpen;
  logic ctrlWr;
  logic causeWr;
  logic monWr;
  logic running;
  logic timeout;
  logic trig;
  logic flagSet;

  always_comb
  begin
    oscTick = state_ff.oscSync[1] & ~state_ff.oscPrev;
    levelTwo = ~state_ff.fuseSync[1];
    wdeEff = state_ff.wdog_reset_enable | flags_ff.wdog_reset_flag | levelTwo;
    protectOpen = state_ff.protectCnt != 3'h0;
    ctrlWr = busReq.we && busReq.addr == wdg_pkg::WDOG_CTRL_ADDR;
    causeWr = busReq.we && busReq.addr == wdg_pkg::RST_CAUSE_ADDR;
    monWr = busReq.we && busReq.addr == wdg_pkg::SUPPLY_MON_ADDR;
    running = wdeEff | state_ff.wdog_irq_enable;
    timeout = running && oscTick && state_ff.cnt == periodLimit(state_ff.wdog_period_select);
    trig = state_ff.supSync[1] &&
           inRange(state_ff.level, wdg_pkg::LEVEL_FLAG_LO, wdg_pkg::LEVEL_FLAG_HI);
    flagSet = trig && !state_ff.trigPrev;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.oscSync = {state_ff.oscSync[0], wdogOscIn};
    nxt_state.extSync = {state_ff.extSync[0], extResetPinN};
    nxt_state.supSync = {state_ff.supSync[0], supplyBelowLevel};
    nxt_state.fuseSync = {state_ff.fuseSync[0], wdogAlwaysOnFuse};
    nxt_state.oscPrev = state_ff.oscSync[1];
    nxt_state.rstPulse = 1'b0;
    nxt_state.vlmIrq = 1'b0;
    nxt_state.rdata = 8'h00;

    // The signature opens a short window; any control write closes it again.
    if (protectOpen)
      nxt_state.protectCnt = state_ff.protectCnt - 3'h1;
    if (busReq.we && busReq.addr == wdg_pkg::CHANGE_PROTECT_ADDR &&
        busReq.wdata == wdg_pkg::CHANGE_SIGNATURE)
      nxt_state.protectCnt = 3'(CCP_WINDOW_CYCLES);

    if (ctrlWr)
    begin
      nxt_state.protectCnt = 3'h0;
      nxt_state.wdog_irq_enable = busReq.wdata[wdg_pkg::WDOG_IRQ_ENABLE_BIT];
      if (busReq.wdata[wdg_pkg::WDOG_IRQ_FLAG_BIT])
        nxt_state.wdog_irq_flag = 1'b0;
      if (levelTwo)
      begin
        if (protectOpen)
          nxt_state.wdog_period_select = {busReq.wdata[wdg_pkg::WDP_HI_BIT], busReq.wdata[2:0]};
      end
      else
      begin
        nxt_state.wdog_period_select = {busReq.wdata[wdg_pkg::WDP_HI_BIT], busReq.wdata[2:0]};
        if (busReq.wdata[wdg_pkg::WDE_BIT])
          nxt_state.wdog_reset_enable = 1'b1;
        else if (protectOpen && !flags_ff.wdog_reset_flag)
          nxt_state.wdog_reset_enable = 1'b0;
      end
    end

    if (wdogVectorAck)
    begin
      nxt_state.wdog_irq_flag = 1'b0;
      // combined mode falls back to reset mode
      if (wdeEff && state_ff.wdog_irq_enable)
        nxt_state.wdog_irq_enable = 1'b0;
    end

    if (!running || kickReq || timeout)
      nxt_state.cnt = '0;
    else if (oscTick)
      nxt_state.cnt = state_ff.cnt + 21'h000001;

    if (timeout)
    begin
      if (levelTwo || (wdeEff && (!state_ff.wdog_irq_enable || state_ff.wdog_irq_flag)))
        nxt_state.rstPulse = 1'b1;
      // interrupt flag, set wins over clear
      else
        nxt_state.wdog_irq_flag = 1'b1;
    end

    if (monWr)
    begin
      nxt_state.supply_monitor_irq_enable = busReq.wdata[wdg_pkg::SUPPLY_MONITOR_IRQ_ENABLE_BIT];
      nxt_state.level = busReq.wdata[2:0];
    end
    nxt_state.trigPrev = trig;
    if ((monWr && (!busReq.wdata[wdg_pkg::SUPPLY_MONITOR_FLAG_BIT] || busReq.wdata[2:0] != state_ff.level)) ||
        state_ff.level == wdg_pkg::LEVEL_OFF || !state_ff.supSync[1])
      nxt_state.supply_monitor_flag = 1'b0;
    if (flagSet)
      nxt_state.supply_monitor_flag = 1'b1;
    if (flagSet && !state_ff.supply_monitor_flag && state_ff.supply_monitor_irq_enable)
      nxt_state.vlmIrq = 1'b1;

    if (busReq.re)
    begin
      case (busReq.addr)
        wdg_pkg::WDOG_CTRL_ADDR:
        begin
          // enable reads one at level two
          nxt_state.rdata[wdg_pkg::WDOG_IRQ_FLAG_BIT] = state_ff.wdog_irq_flag;
          nxt_state.rdata[wdg_pkg::WDOG_IRQ_ENABLE_BIT] = state_ff.wdog_irq_enable;
          nxt_state.rdata[wdg_pkg::WDP_HI_BIT] = state_ff.wdog_period_select[3];
          nxt_state.rdata[wdg_pkg::WDE_BIT] = wdeEff;
          nxt_state.rdata[2:0] = state_ff.wdog_period_select[2:0];
        end
        wdg_pkg::RST_CAUSE_ADDR:
        begin
          nxt_state.rdata[wdg_pkg::WDOG_RESET_FLAG_BIT] = flags_ff.wdog_reset_flag;
          nxt_state.rdata[wdg_pkg::EXT_PIN_RESET_FLAG_BIT] = flags_ff.ext_pin_reset_flag;
          nxt_state.rdata[wdg_pkg::POWER_ON_RESET_FLAG_BIT] = flags_ff.power_on_reset_flag;
        end
        wdg_pkg::SUPPLY_MON_ADDR:
        begin
          nxt_state.rdata[wdg_pkg::SUPPLY_MONITOR_FLAG_BIT] = state_ff.supply_monitor_flag;
          nxt_state.rdata[wdg_pkg::SUPPLY_MONITOR_IRQ_ENABLE_BIT] = state_ff.supply_monitor_irq_enable;
          nxt_state.rdata[2:0] = state_ff.level;
        end
        default:
          nxt_state.rdata = 8'h00;
      endcase
    end
  end

  // The cause flags must survive the device reset, so only the power-on
  // reset touches them; software may clear but never set them.
  always_comb
  begin
    nxt_flags = flags_ff;
    if (causeWr)
    begin
      if (!busReq.wdata[wdg_pkg::WDOG_RESET_FLAG_BIT])
        nxt_flags.wdog_reset_flag = 1'b0;
      if (!busReq.wdata[wdg_pkg::EXT_PIN_RESET_FLAG_BIT])
        nxt_flags.ext_pin_reset_flag = 1'b0;
      // power-on flag cleared by write only
      if (!busReq.wdata[wdg_pkg::POWER_ON_RESET_FLAG_BIT])
        nxt_flags.power_on_reset_flag = 1'b0;
    end
    if (state_ff.rstPulse)
      nxt_flags.wdog_reset_flag = 1'b1;
    if (!state_ff.extSync[1])
      nxt_flags.ext_pin_reset_flag = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= '0;
      state_ff.extSync <= 2'h3;
      state_ff.fuseSync <= 2'h3;
      state_ff.wdog_period_select <= wdg_pkg::PERIOD_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge ref_clk or negedge porRstn)
  begin
    if (!porRstn)
    begin
      flags_ff.wdog_reset_flag <= 1'b0;
      flags_ff.ext_pin_reset_flag <= 1'b0;
      flags_ff.power_on_reset_flag <= 1'b1;
    end
    else
      flags_ff <= nxt_flags;
  end

  assign busRdata = state_ff.rdata;
  assign wdogIrqReq = state_ff.wdog_irq_flag & state_ff.wdog_irq_enable & globalIrqEnable;
  assign supplyMonitorIrq = state_ff.vlmIrq;
  assign sysResetPulse = state_ff.rstPulse;
  assign supplyPorReq = state_ff.supSync[1] &&
                        inRange(state_ff.level, wdg_pkg::LEVEL_POR_LO, wdg_pkg::LEVEL_POR_HI);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  sequence firstTimeoutIrq;
    timeout && !levelTwo && state_ff.wdog_irq_enable && !state_ff.wdog_irq_flag;
  endsequence

  sequence secondTimeoutCombined;
    timeout && wdeEff && state_ff.wdog_irq_enable && state_ff.wdog_irq_flag;
  endsequence

  reset_pulse_a: assert property (sysResetPulse |=> !sysResetPulse)
    else $error("Watchdog reset pulse longer than one cycle");
  irq_flag_set_a: assert property (firstTimeoutIrq |=> state_ff.wdog_irq_flag && !sysResetPulse)
    else $error("First interrupt time-out did not set the flag");
  combined_reset_a: assert property (secondTimeoutCombined |=> sysResetPulse)
    else $error("Unserviced combined interrupt did not reset");
  fuse_reset_a: assert property (timeout && levelTwo |=> sysResetPulse)
    else $error("Programmed fuse time-out did not reset");
  vector_clear_a: assert property (wdogVectorAck && !timeout |=> !state_ff.wdog_irq_flag)
    else $error("Vector did not clear the interrupt flag");
  combined_vec_a: assert property (wdogVectorAck && wdeEff && state_ff.wdog_irq_enable
                                   |=> !state_ff.wdog_irq_enable)
    else $error("Vector in combined mode kept interrupt enable");
  unprot_disable_a: assert property (ctrlWr && !protectOpen && state_ff.wdog_reset_enable &&
                                     !busReq.wdata[wdg_pkg::WDE_BIT] |=> state_ff.wdog_reset_enable)
    else $error("Enable cleared without protected sequence");
  level_two_read_a: assert property (busReq.re && busReq.addr == wdg_pkg::WDOG_CTRL_ADDR &&
                                     levelTwo |=> busRdata[wdg_pkg::WDE_BIT])
    else $error("Enable read as zero at level two");
  period_guard_a: assert property (ctrlWr && levelTwo && !protectOpen
                                   |=> $stable(state_ff.wdog_period_select))
    else $error("Period changed without protected sequence");
  wdog_reset_flag_hold_a: assert property (flags_ff.wdog_reset_flag && ctrlWr |=> state_ff.wdog_reset_enable == $past(state_ff.wdog_reset_enable)
                                || state_ff.wdog_reset_enable)
    else $error("Enable cleared while reset flag set");
  kick_restart_a: assert property (kickReq |=> state_ff.cnt == '0)
    else $error("Kick did not restart the counter");
  wdog_reset_flag_set_a: assert property (sysResetPulse |=> flags_ff.wdog_reset_flag)
    else $error("Watchdog reset did not set its flag");
  supply_irq_a: assert property (supplyMonitorIrq |-> state_ff.supply_monitor_flag && state_ff.supply_monitor_irq_enable)
    else $error("Supply interrupt without flag and enable");
  irq_req_a: assert property (wdogIrqReq |-> state_ff.wdog_irq_flag && globalIrqEnable)
    else $error("Interrupt request without flag or global enable");
  // The counter must not move between oscillator ticks, whatever the bus does.
  cnt_hold_a: assert property (running && !oscTick && !kickReq |=> $stable(state_ff.cnt))
    else $error("Counter moved without an oscillator tick");
  level_off_a: assert property (state_ff.level == wdg_pkg::LEVEL_OFF |=> !state_ff.supply_monitor_flag)
    else $error("Supply flag set while monitor disabled");
  por_hold_a: assert property (flags_ff.power_on_reset_flag && !causeWr |=> flags_ff.power_on_reset_flag)
    else $error("Power-on flag cleared without a write");

endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic ref_clk;
  logic rstn;
  logic porRstn;
  logic kickReq;
  logic wdogVectorAck;
  logic globalIrqEnable;
  logic wdogOscIn;
  logic extResetPinN;
  logic supplyBelowLevel;
  logic wdogAlwaysOnFuse;
  logic wdogIrqReq;
  logic supplyMonitorIrq;
  logic sysResetPulse;
  logic supplyPorReq;
  logic prevRst;
  logic [7:0] busRdata;
  logic [7:0] v;
  logic [2:0] oscDiv;
  wdg_pkg::wdg_bus_req_t busReq;
  int n_fail;
  int checks_done;
  int cycles;
  int rstPulses;
  int longPulse;
  int supPulses;
  int n;

  wdg_watchdog uut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .porRstn(porRstn),
    .busReq(busReq),
    .busRdata(busRdata),
    .kickReq(kickReq),
    .wdogVectorAck(wdogVectorAck),
    .globalIrqEnable(globalIrqEnable),
    .wdogIrqReq(wdogIrqReq),
    .supplyMonitorIrq(supplyMonitorIrq),
    .wdogOscIn(wdogOscIn),
    .extResetPinN(extResetPinN),
    .supplyBelowLevel(supplyBelowLevel),
    .wdogAlwaysOnFuse(wdogAlwaysOnFuse),
    .sysResetPulse(sysResetPulse),
    .supplyPorReq(supplyPorReq)
  );

  // The oscillator runs far faster than in silicon so that a time-out fits the run.
  assign wdogOscIn = oscDiv[2];

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    oscDiv <= oscDiv + 3'h1;
    prevRst <= sysResetPulse;
    if (sysResetPulse === 1'b1 && prevRst !== 1'b1) rstPulses <= rstPulses + 1;
    if (sysResetPulse === 1'b1 && prevRst === 1'b1) longPulse <= longPulse + 1;
    if (supplyMonitorIrq === 1'b1) supPulses <= supPulses + 1;
    if (cycles == 90000)
    begin
      n_fail = n_fail + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  // One idle cycle after each write so the strobe never changes twice in a step.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge ref_clk);
    busReq.we <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [5:0] a);
    busReq <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge ref_clk);
    busReq.re <= 1'b0;
    @(negedge ref_clk);
    v = busRdata;
    @(posedge ref_clk);
  endtask

  task automatic wait_irq();
    n = 0;
    while (wdogIrqReq !== 1'b1 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  task automatic t_reset();
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h00);
    rd(wdg_pkg::RST_CAUSE_ADDR); chk(v, 8'h01);
    rd(6'h3f); chk(v, 8'h00);
  endtask

  task automatic t_level_one();
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h08);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h00);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::CHANGE_PROTECT_ADDR, wdg_pkg::CHANGE_SIGNATURE);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h21);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h21);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_irq_mode();
    globalIrqEnable <= 1'b1;
    kickReq <= 1'b1;
    @(posedge ref_clk);
    kickReq <= 1'b0;
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h40);
    wait_irq();
    chk(8'(n > 16360 && n < 16400), 8'h01);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'hc0);
    chk(8'(rstPulses), 8'h00);
    globalIrqEnable <= 1'b0;
    cyc(2);
    chk({7'h0, wdogIrqReq}, 8'h00);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'hc0);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h40);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_combined();
    globalIrqEnable <= 1'b1;
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h48);
    wait_irq();
    chk({7'h0, wdogIrqReq}, 8'h01);
    wdogVectorAck <= 1'b1;
    @(posedge ref_clk);
    wdogVectorAck <= 1'b0;
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h48);
    wait_irq();
    chk(8'(rstPulses), 8'h00);
    n = 0;
    while (rstPulses == 0 && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
    cyc(2);
    chk(8'(rstPulses), 8'h01);
    chk(8'(longPulse), 8'h00);
    rd(wdg_pkg::RST_CAUSE_ADDR); chk(v, 8'h09);
    wr(wdg_pkg::CHANGE_PROTECT_ADDR, wdg_pkg::CHANGE_SIGNATURE);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h80);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::RST_CAUSE_ADDR, 8'h00);
    rd(wdg_pkg::RST_CAUSE_ADDR); chk(v, 8'h00);
    wr(wdg_pkg::CHANGE_PROTECT_ADDR, wdg_pkg::CHANGE_SIGNATURE);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h00);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h00);
  endtask

  task automatic t_ext_and_supply();
    extResetPinN <= 1'b0;
    cyc(4);
    extResetPinN <= 1'b1;
    cyc(3);
    rd(wdg_pkg::RST_CAUSE_ADDR); chk(v, 8'h02);
    wr(wdg_pkg::SUPPLY_MON_ADDR, 8'h43);
    supplyBelowLevel <= 1'b1;
    cyc(6);
    chk(8'(supPulses), 8'h01);
    rd(wdg_pkg::SUPPLY_MON_ADDR); chk(v, 8'hc3);
    supplyBelowLevel <= 1'b0;
    cyc(6);
    rd(wdg_pkg::SUPPLY_MON_ADDR); chk(v, 8'h43);
    wr(wdg_pkg::SUPPLY_MON_ADDR, 8'h01);
    supplyBelowLevel <= 1'b1;
    cyc(6);
    chk({7'h0, supplyPorReq}, 8'h01);
    rd(wdg_pkg::SUPPLY_MON_ADDR); chk(v, 8'h01);
    supplyBelowLevel <= 1'b0;
    wr(wdg_pkg::SUPPLY_MON_ADDR, 8'h00);
  endtask

  task automatic t_level_two();
    wdogAlwaysOnFuse <= 1'b0;
    cyc(4);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h03);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h08);
    wr(wdg_pkg::CHANGE_PROTECT_ADDR, wdg_pkg::CHANGE_SIGNATURE);
    wr(wdg_pkg::WDOG_CTRL_ADDR, 8'h03);
    rd(wdg_pkg::WDOG_CTRL_ADDR); chk(v, 8'h0b);
  endtask

  initial
  begin
    rstn = 1'b0;
    porRstn = 1'b0;
    kickReq = 1'b0;
    wdogVectorAck = 1'b0;
    globalIrqEnable = 1'b0;
    extResetPinN = 1'b1;
    supplyBelowLevel = 1'b0;
    wdogAlwaysOnFuse = 1'b1;
    oscDiv = 3'h0;
    prevRst = 1'b0;
    busReq = '0;
    cyc(12);
    rstn <= 1'b1;
    porRstn <= 1'b1;
    cyc(2);
    t_reset();
    t_level_one();
    t_irq_mode();
    t_combined();
    t_ext_and_supply();
    t_level_two();
    finish_test();
  end
endmodule

`default_nettype wire
